// file: rtl/sgpio_pkg.sv
package sgpio_pkg;
    localparam int          SGPIO_WIDTH      = 6;
    localparam int          SGPIO_IN_ONLY    = 3;
    localparam logic [3:0]  SGPIO_A_LEVELS   = 4'h0;
    localparam logic [3:0]  SGPIO_A_DIR      = 4'h4;
    localparam logic [3:0]  SGPIO_A_LATCH    = 4'h8;
    localparam logic [3:0]  SGPIO_A_CHG_EN   = 4'hC;
    localparam logic [7:0]  SGPIO_OFS_CTRL   = 8'h10;
    localparam logic [7:0]  SGPIO_OFS_STAT   = 8'h14;
    localparam logic [7:0]  SGPIO_OFS_CLR    = 8'h18;
    localparam logic [5:0]  SGPIO_DIR_RESET  = 6'h3F;
    localparam logic [5:0]  SGPIO_XTAL_MASK  = 6'h30;
    localparam int          SGPIO_CTRL_IRQEN = 0;
    localparam int          SGPIO_STAT_FLAG  = 0;
    localparam logic [1:0]  SGPIO_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  SGPIO_RESP_DEC   = 2'h3;
endpackage

// file: rtl/sgpio_port.sv
`timescale 1ns/1ps
module sgpio_port
    import sgpio_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [5:0]  pin_in,
    output logic [5:0]       pin_out,
    output logic [5:0]       pin_oe,
    input  wire logic        master_clear_enable_cfg,
    input  wire logic        crystal_osc_mode,
    input  wire logic [5:0]  periph_en,
    input  wire logic [5:0]  periph_out,
    input  wire logic [5:0]  periph_oe,
    input  wire logic        other_port_change,
    output logic             change_irq
);

    // ----------------------------------------------------------------
    // Pin synchronisers and register state
    // ----------------------------------------------------------------
    logic [5:0] sync1, sync2, sync3, pin_level;
    logic [5:0] direction_reg, output_latch_reg, change_enable_reg, snapshot;
    logic       change_irq_enable, change_irq_flag, other1, other2, other3;
    logic [5:0] next_direction_reg, next_output_latch_reg, next_change_enable_reg;
    logic [5:0] next_snapshot, next_pin_level, next_pin_out, next_pin_oe;
    logic       next_change_irq_enable, next_change_irq_flag, next_change_irq;

    logic        wr_pend_a, wr_pend_d, bvalid, arready_q, rvalid;
    logic [7:0]  waddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        next_wr_pend_a, next_wr_pend_d, next_bvalid, next_rvalid;
    logic [7:0]  next_waddr;
    logic [31:0] next_wdata, next_rdata;
    logic [1:0]  next_bresp, next_rresp;
    logic [3:0]  wstrb;
    logic [3:0]  next_wstrb;
    logic        next_arready, next_awready, next_wready;

    // ----------------------------------------------------------------
    // Address decode and read multiplexer
    // ----------------------------------------------------------------
    function automatic logic [3:0] reg_sel(input logic [7:0] addr);
        reg_sel = addr[3:0];
        if (addr[1:0] != 2'h0 || addr[7:4] != 4'h0) begin
            reg_sel = 4'hF;
        end
    endfunction

    // Reads and writes share one decoder so the two responses cannot drift apart.
    // The status word is read only and the clear word is write only.
    function automatic logic [1:0] addr_resp(input logic [7:0] addr, input logic is_write);
        addr_resp = SGPIO_RESP_OKAY;
        if (reg_sel(addr) == 4'hF && addr != SGPIO_OFS_CTRL && addr != SGPIO_OFS_STAT
            && !(is_write && addr == SGPIO_OFS_CLR)) begin
            addr_resp = SGPIO_RESP_DEC;
        end
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] addr);
        logic [5:0] lv;
        logic [5:0] dr;
        lv = pin_level;
        dr = direction_reg;
        read_word = 32'h0;
        // The pin three level is hidden while the pin serves as master clear.
        lv[SGPIO_IN_ONLY] = pin_level[SGPIO_IN_ONLY] & ~master_clear_enable_cfg;
        dr[SGPIO_IN_ONLY] = 1'b1;
        if (crystal_osc_mode) begin
            dr = dr | SGPIO_XTAL_MASK;
        end
        case (addr)
            {4'h0, SGPIO_A_LEVELS}: read_word = {26'h0, lv};
            {4'h0, SGPIO_A_DIR}:    read_word = {26'h0, dr};
            {4'h0, SGPIO_A_LATCH}:  read_word = {26'h0, output_latch_reg};
            {4'h0, SGPIO_A_CHG_EN}: read_word = {26'h0, change_enable_reg};
            SGPIO_OFS_CTRL:         read_word = {31'h0, change_irq_enable};
            SGPIO_OFS_STAT:         read_word = {31'h0, change_irq_flag};
            default:                read_word = 32'h0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Register file and change detection
    // ----------------------------------------------------------------
    logic       do_wr, rd_levels, do_rd;
    logic [5:0] mismatch;
    always_comb begin
        do_wr = wr_pend_a && wr_pend_d && !bvalid;
        do_rd = s_axi_arvalid && arready_q;
        rd_levels = do_rd && (s_axi_araddr == {4'h0, SGPIO_A_LEVELS});
        next_direction_reg = direction_reg;
        next_output_latch_reg = output_latch_reg;
        next_change_enable_reg = change_enable_reg;
        next_change_irq_enable = change_irq_enable;
        // A level counts once the second and third stages agree, so a pin
        // caught in mid-transition never reaches the comparison.
        next_pin_level = (sync2 == sync3) ? sync3 : pin_level;
        next_snapshot = rd_levels ? pin_level : snapshot;
        // Only input pins that are enabled take part in the comparison.
        mismatch = (pin_level ^ snapshot) & change_enable_reg & direction_reg;
        next_change_irq_flag = change_irq_flag;
        if (do_wr && wstrb_ok()) begin
            case (waddr)
                {4'h0, SGPIO_A_LEVELS}, {4'h0, SGPIO_A_LATCH}:
                    next_output_latch_reg = wdata[5:0];
                {4'h0, SGPIO_A_DIR}:    next_direction_reg = wdata[5:0];
                {4'h0, SGPIO_A_CHG_EN}: next_change_enable_reg = wdata[5:0];
                SGPIO_OFS_CTRL:         next_change_irq_enable = wdata[SGPIO_CTRL_IRQEN];
                SGPIO_OFS_CLR: begin
                    if (wdata[SGPIO_STAT_FLAG]) begin
                        next_change_irq_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Pin three stays an input whatever software writes to its direction bit.
        next_direction_reg[SGPIO_IN_ONLY] = 1'b1;
        // A new mismatch wins over a clear in the same cycle; software must
        // end the mismatch by reading the levels first.
        if ((|mismatch) || other3 != other2) begin
            next_change_irq_flag = 1'b1;
        end
        next_change_irq = change_irq_flag && change_irq_enable;
        for (int i = 0; i < SGPIO_WIDTH; i++) begin
            if (periph_en[i]) begin
                next_pin_out[i] = periph_out[i];
                next_pin_oe[i] = periph_oe[i];
            end else begin
                next_pin_out[i] = output_latch_reg[i];
                next_pin_oe[i] = ~direction_reg[i] && (i != SGPIO_IN_ONLY);
            end
        end
        // No peripheral may drive the input-only pin either.
        next_pin_oe[SGPIO_IN_ONLY] = 1'b0;
    end

    // The strobe is kept with its data; the master may drop it before the write lands.
    function automatic logic wstrb_ok();
        wstrb_ok = wstrb[0];
    endfunction

    // ----------------------------------------------------------------
    // Register file flops
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            sync3 <= 6'h00;
            other1 <= 1'b0;
            other2 <= 1'b0;
            other3 <= 1'b0;
            pin_level <= 6'h00;
            snapshot <= 6'h00;
            direction_reg <= SGPIO_DIR_RESET;
            output_latch_reg <= 6'h00;
            change_enable_reg <= 6'h00;
            change_irq_enable <= 1'b0;
            change_irq_flag <= 1'b0;
            change_irq <= 1'b0;
            pin_out <= 6'h00;
            pin_oe <= 6'h00;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            other1 <= other_port_change;
            other2 <= other1;
            other3 <= other2;
            pin_level <= next_pin_level;
            snapshot <= next_snapshot;
            direction_reg <= next_direction_reg;
            output_latch_reg <= next_output_latch_reg;
            change_enable_reg <= next_change_enable_reg;
            change_irq_enable <= next_change_irq_enable;
            change_irq_flag <= next_change_irq_flag;
            change_irq <= next_change_irq;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    always_comb begin
        next_wr_pend_a = wr_pend_a;
        next_wr_pend_d = wr_pend_d;
        next_waddr = waddr;
        next_wdata = wdata;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_wstrb = wstrb;
        // Each channel is taken only on its own handshake, so nothing slips in
        // during the cycle right after reset while the ready flags are still low.
        if (s_axi_awvalid && s_axi_awready) begin
            next_wr_pend_a = 1'b1;
            next_waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wr_pend_d = 1'b1;
            next_wdata = s_axi_wdata;
            next_wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            next_bvalid = 1'b1;
            next_bresp = addr_resp(waddr, 1'b1);
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
            next_wr_pend_a = 1'b0;
            next_wr_pend_d = 1'b0;
        end
        if (do_rd) begin
            next_rvalid = 1'b1;
            next_rdata = read_word(s_axi_araddr);
            next_rresp = addr_resp(s_axi_araddr, 1'b0);
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // One read at a time: ready only while no answer is pending.
        next_arready = !next_rvalid && !do_rd;
        next_awready = !next_wr_pend_a;
        next_wready = !next_wr_pend_d;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_pend_a <= 1'b0;
            wr_pend_d <= 1'b0;
            waddr <= 8'h00;
            wdata <= 32'h0;
            wstrb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
            arready_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            wr_pend_a <= next_wr_pend_a;
            wr_pend_d <= next_wr_pend_d;
            waddr <= next_waddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            arready_q <= next_arready;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

endmodule

// file: verification/sgpio_pins_model.sv
`timescale 1ns/1ps
// ----------
// Pin circuitry
// ----------
module sgpio_pins_model (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] ext_val,
    output logic      [5:0] pin_in
);
    // A released pin follows the external source, whose idle level is the pull-up.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// file: verification/sgpio_port_asserts.sv
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module sgpio_port_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [5:0]  pin_oe,
    input wire logic        change_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // The interrupt falls one edge after a write lands, and the write response
    // stands at that edge, so a quiet response channel means no fall is due.
    sequence s_no_write;
        !s_axi_bvalid;
    endsequence
    AST_PIN3_INPUT: assert property (!pin_oe[3])
        else $error("pin three driven");
    AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == '0)
        else $error("upper read bits set");
    AST_IRQ_STICKY: assert property (change_irq ##0 s_no_write |=> change_irq)
        else $error("interrupt dropped without a write");
    AST_B_AFTER_WRITE: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_R_AFTER_READ: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_RETIRE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not retired");
    AST_AW_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while pending");
    AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while pending");
endmodule
bind sgpio_port sgpio_port_asserts u_chk (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_oe, .change_irq);

// file: verification/six_bit_gpio_port_with_ioc_bench.sv
`timescale 1ns/1ps
// ----------
// Bench
// ----------
module six_bit_gpio_port_with_ioc_bench import sgpio_pkg::*;;
    logic sys_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, irq, mclr = 0, xtal = 0, other = 0;
    logic [1:0] bresp, rresp, r;
    logic [5:0] pin_in, pin_out, pin_oe, ext = 6'h3F, pen = 0, pout = 0, poe = 0;
    int n_fail = 0, samples_checked = 0;
    sgpio_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .master_clear_enable_cfg(mclr),
        .crystal_osc_mode(xtal), .periph_en(pen), .periph_out(pout), .periph_oe(poe),
        .other_port_change(other), .change_irq(irq));
    sgpio_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext), .pin_in(pin_in));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask
    task automatic rd(logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    task automatic rc(string what, logic [7:0] a, logic [31:0] exp);
        rd(a);
        chk(what, exp, d);
    endtask
    task automatic t_reset;
        rc("dir", SGPIO_A_DIR, 32'h3F);
        rc("latch", SGPIO_A_LATCH, 32'h0);
        rc("chg_en", SGPIO_A_CHG_EN, 32'h0);
        rc("stat", SGPIO_OFS_STAT, 32'h0);
    endtask
    task automatic t_drive;
        wr(SGPIO_A_DIR, 32'h0);
        rc("dir", SGPIO_A_DIR, 32'h08);
        wr(SGPIO_A_LEVELS, 32'h15);
        rc("latch", SGPIO_A_LATCH, 32'h15);
        cyc(3);
        chk("oe", 32'h37, pin_oe);
        chk("out", 32'h15, pin_out & 6'h37);
        cyc(4);
        rc("levels", SGPIO_A_LEVELS, 32'h1D);
        ext <= 6'h2A;
        wr(SGPIO_A_DIR, 32'hFF);
        cyc(6);
        chk("oe", 32'h0, pin_oe);
        rc("levels", SGPIO_A_LEVELS, 32'h2A);
        rc("latch", SGPIO_A_LATCH, 32'h15);
    endtask
    task automatic t_mask;
        mclr <= 1'b1;
        xtal <= 1'b1;
        cyc(2);
        rc("levels", SGPIO_A_LEVELS, 32'h22);
        wr(SGPIO_A_DIR, 32'h0);
        rc("dir", SGPIO_A_DIR, 32'h38);
        mclr <= 1'b0;
        xtal <= 1'b0;
        wr(SGPIO_A_DIR, 32'h3F);
        cyc(6);
    endtask
    task automatic t_ioc;
        rd(SGPIO_A_LEVELS);
        wr(SGPIO_A_CHG_EN, 32'h01);
        wr(SGPIO_OFS_CTRL, 32'h01);
        ext <= 6'h28;
        cyc(8);
        chk("irq", 32'h0, irq);
        ext <= 6'h29;
        cyc(8);
        chk("irq", 32'h1, irq);
        rc("stat", SGPIO_OFS_STAT, 32'h1);
        wr(SGPIO_OFS_CTRL, 32'h0);
        cyc(2);
        chk("irq", 32'h0, irq);
        wr(SGPIO_OFS_CTRL, 32'h1);
        wr(SGPIO_OFS_CLR, 32'h1);
        cyc(3);
        chk("irq", 32'h1, irq);
        rd(SGPIO_A_LEVELS);
        wr(SGPIO_OFS_CLR, 32'h1);
        rc("stat", SGPIO_OFS_STAT, 32'h0);
    endtask
    task automatic t_other;
        other <= ~other;
        cyc(8);
        chk("irq", 32'h1, irq);
        wr(SGPIO_OFS_CLR, 32'h1);
        cyc(3);
        chk("irq", 32'h0, irq);
    endtask
    task automatic t_out;
        wr(SGPIO_A_LEVELS, 32'h14);
        wr(SGPIO_A_DIR, 32'h3E);
        cyc(8);
        chk("irq", 32'h0, irq);
        rd(8'h1C);
        chk("decerr", SGPIO_RESP_DEC, r);
    endtask
    task automatic t_periph;
        pen <= 6'h09;
        pout <= 6'h01;
        poe <= 6'h09;
        cyc(4);
        chk("periph", 32'h3, {pin_oe[0], pin_out[0]});
        chk("pin3_oe", 32'h0, pin_oe[3]);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
        t_reset();
        t_drive();
        t_mask();
        t_ioc();
        t_other();
        t_out();
        t_periph();
        test_done();
    end
    initial begin
        cyc(5000);
        n_fail++;
        test_done();
    end
endmodule
